// File: verilog/switch_test_jump.v
// Summary of operation
// RL1 - operation code 38 selects the switch-test jump
// RL2 - odd sign digit adds index register to target; even does not
// RL3 - switch-select field chooses which control switch is tested
// RL4 - switch on: program counter takes the (modified) target address
// RL5 - switch off: program counter becomes its starting value plus 1
// RL6 - accumulator, auxiliary and index kept; exchange register cleared
// RL7 - middle three-digit field is ignored
// RL8 - four-digit address field is the alternate instruction base
`timescale 1ns/1ps
`default_nettype none
`include "switch_test_defines.vh"
module switch_test_jump (
	input  wire                    REF_CLK_IN,
	input  wire                    RST_IN,
	input  wire                    START_IN,
	input  wire [`WORD_W-1:0]      INSTR_IN,
	input  wire [`ADDR_W-1:0]      PC_IN,
	input  wire [`ADDR_W-1:0]      INDEX_IN,
	input  wire [`NUM_SW-1:0]      SWITCH_IN,
	output reg                     DONE_OUT,
	output reg                     TAKEN_OUT,
	output reg                     PC_LOAD_OUT,
	output reg  [`ADDR_W-1:0]      PC_OUT,
	output reg                     EXCH_CLEAR_OUT,
	output reg                     ILLEGAL_OUT
);

	// ****************************************************
	// state codes
	// ****************************************************
	localparam [1:0] ST_IDLE = `ST_IDLE;
	localparam [1:0] ST_CALC = `ST_CALC;

	// ****************************************************
	// working registers and their next values
	// ****************************************************
	reg  [1:0]         state_q;
	reg  [`WORD_W-1:0] instr_q;
	reg  [`ADDR_W-1:0] pc_q;
	reg  [`ADDR_W-1:0] index_q;

	reg  [1:0]         state_d;
	reg  [`WORD_W-1:0] instr_d;
	reg  [`ADDR_W-1:0] pc_d;
	reg  [`ADDR_W-1:0] index_d;
	reg                done_d;
	reg                taken_d;
	reg                pc_load_d;
	reg  [`ADDR_W-1:0] pc_out_d;
	reg                exch_clear_d;
	reg                illegal_d;

	// ****************************************************
	// instruction fields
	// ****************************************************
	wire [3:0]         sign_dig;
	wire [`SEL_W-1:0]  sel;
	wire [`ADDR_W-1:0] base;
	wire [7:0]         opc_in;
	wire               is_jump;
	wire               index_mod;

	assign sign_dig  = instr_q[`SIGN_MSB:`SIGN_LSB];
	assign sel       = instr_q[`SEL_MSB:`SEL_LSB];
	assign base      = instr_q[`ADDR_MSB:`ADDR_LSB]; // RL8
	// middle digits are never looked at
	// RL7
	assign opc_in    = INSTR_IN[`OPC_MSB:`OPC_LSB];
	assign is_jump   = (opc_in == `OPC_SWJ); // RL1
	// odd sign digit: low bit of the bcd digit
	assign index_mod = sign_dig[0]; // RL2

	// ****************************************************
	// address arithmetic
	// ****************************************************
	wire [`ADDR_W-1:0] mod_val;
	wire [`ADDR_W-1:0] target;
	wire [`ADDR_W-1:0] next_seq;

	assign mod_val = index_mod ? index_q : `ADDR_RST; // RL2
	bcd_add4 u_target (
		.a_in    (base),
		.b_in    (mod_val),
		.sum_out (target)
	);

	bcd_add4 u_seq (
		.a_in    (pc_q),
		.b_in    (16'h0001),
		.sum_out (next_seq)
	);

	// ****************************************************
	// switch selection
	// ****************************************************
	wire [`NUM_SW-1:0] sw_hit;
	wire               sw_on;
	genvar             g;

	generate
		for (g = 0; g < `NUM_SW; g = g + 1) begin : g_sw
			assign sw_hit[g] = (sel == g) & SWITCH_IN[g]; // RL3
		end
	endgenerate
	// select codes past the last switch match no bit and read as off
	assign sw_on = |sw_hit; // RL3

	// ****************************************************
	// next-state and result decode
	// ****************************************************
	always @* begin
		state_d      = state_q;
		instr_d      = instr_q;
		pc_d         = pc_q;
		index_d      = index_q;
		done_d       = 1'b0;
		taken_d      = TAKEN_OUT;
		pc_load_d    = 1'b0;
		pc_out_d     = PC_OUT;
		exch_clear_d = 1'b0;
		illegal_d    = 1'b0;

		case (state_q)
		ST_IDLE: begin
			if (START_IN) begin
				if (is_jump) begin // RL1
					instr_d = INSTR_IN;
					pc_d    = PC_IN;
					index_d = INDEX_IN;
					state_d = ST_CALC;
				end else begin
					// wrong opcode: one illegal pulse, nothing captured
					illegal_d = 1'b1;
				end
			end
		end

		ST_CALC: begin
			// a start seen in this cycle is dropped
			if (sw_on) begin
				pc_out_d = target; // RL4
				taken_d  = 1'b1;
			end else begin
				pc_out_d = next_seq; // RL5
				taken_d  = 1'b0;
			end
			pc_load_d    = 1'b1;
			// besides the program counter load, only the exchange register is touched
			exch_clear_d = 1'b1; // RL6
			done_d       = 1'b1;
			state_d      = ST_IDLE;
		end

		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	// ****************************************************
	// sequencing state
	// ****************************************************
	always @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************************
	// captured operands
	// ****************************************************
	always @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			instr_q <= {`WORD_W{1'b0}};
			pc_q    <= `ADDR_RST;
			index_q <= `ADDR_RST;
		end else begin
			instr_q <= instr_d;
			pc_q    <= pc_d;
			index_q <= index_d;
		end
	end

	// ****************************************************
	// one-cycle completion pulses
	// ****************************************************
	// accumulator, auxiliary and index registers have no path out of
	// this block, so they keep their contents through the jump
	always @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			DONE_OUT       <= 1'b0;
			PC_LOAD_OUT    <= 1'b0;
			EXCH_CLEAR_OUT <= 1'b0;
			ILLEGAL_OUT    <= 1'b0;
		end else begin
			DONE_OUT       <= done_d;
			PC_LOAD_OUT    <= pc_load_d;
			EXCH_CLEAR_OUT <= exch_clear_d; // RL6
			ILLEGAL_OUT    <= illegal_d;
		end
	end

	// ****************************************************
	// result held until the next completion
	// ****************************************************
	always @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			TAKEN_OUT <= 1'b0;
			PC_OUT    <= `ADDR_RST;
		end else begin
			TAKEN_OUT <= taken_d;
			PC_OUT    <= pc_out_d; // RL4 RL5
		end
	end

endmodule
`default_nettype wire

// File: verilog/switch_test_defines.vh
`ifndef SWITCH_TEST_DEFINES_VH
`define SWITCH_TEST_DEFINES_VH
// ****************************************************
// instruction word: 11 bcd digits, sign digit on top
// ****************************************************
`define WORD_W        44
`define SIGN_MSB      43
`define SIGN_LSB      40
`define SEL_MSB       39
`define SEL_LSB       36
`define MID_MSB       35
`define MID_LSB       24
`define OPC_MSB       23
`define OPC_LSB       16
`define ADDR_MSB      15
`define ADDR_LSB      0
`define ADDR_W        16
`define SEL_W         4
`define NUM_SW        10
`define OPC_SWJ       8'h38
`define ADDR_RST      16'h0000
`define ST_IDLE       2'h0
`define ST_CALC       2'h1
`define ST_DONE       2'h2
`endif

// File: verilog/bcd_add4.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// four-digit bcd adder, carry out of the top digit dropped
// ****************************************************
module bcd_add4 (
	input  wire [15:0] a_in,
	input  wire [15:0] b_in,
	output wire [15:0] sum_out
);
	reg  [15:0] s;
	reg  [4:0]  d;
	reg         c;
	integer     i;
	always @* begin
		s = 16'h0000;
		c = 1'b0;
		d = 5'h00;
		for (i = 0; i < 4; i = i + 1) begin
			d = {1'b0, a_in[i*4 +: 4]} + {1'b0, b_in[i*4 +: 4]}
				+ {4'h0, c};
			if (d > 5'h09) begin
				d = d + 5'h06;
				c = 1'b1;
			end else begin
				c = 1'b0;
			end
			s[i*4 +: 4] = d[3:0];
		end
	end
	assign sum_out = s;
endmodule
`default_nettype wire

// File: dv/console_switches.sv
`timescale 1ns/1ps
`default_nettype none
module console_switches (
	input  wire [9:0] level_in,
	output wire [9:0] switch_out
);
	assign switch_out = level_in;
endmodule
`default_nettype wire

// File: dv/switch_test_checker.sv
`timescale 1ns/1ps
`default_nettype none
module switch_test_checker (
	input wire        REF_CLK_IN,
	input wire        RST_IN,
	input wire        START_IN,
	input wire [43:0] INSTR_IN,
	input wire [9:0]  SWITCH_IN,
	input wire        DONE_OUT,
	input wire        TAKEN_OUT,
	input wire        PC_LOAD_OUT,
	input wire [15:0] PC_OUT,
	input wire        EXCH_CLEAR_OUT,
	input wire        ILLEGAL_OUT
);
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (RST_IN);
	reg [3:0] sel_q;
	always @(posedge REF_CLK_IN) if (START_IN) sel_q <= INSTR_IN[39:36];
	a_jump_done: assert property (START_IN && INSTR_IN[23:16] == 8'h38 |-> ##2 DONE_OUT) else $error("no done");
	a_bad_op: assert property (START_IN && INSTR_IN[23:16] != 8'h38 |=> ILLEGAL_OUT) else $error("no illegal");
	a_done_set: assert property (DONE_OUT |-> PC_LOAD_OUT && EXCH_CLEAR_OUT) else $error("pulses apart");
	a_sel_sw: assert property (DONE_OUT |-> TAKEN_OUT == $past((sel_q < 4'ha) && SWITCH_IN[sel_q])) else $error("wrong switch");
	a_even_addr: assert property (DONE_OUT && TAKEN_OUT && !$past(INSTR_IN[40], 2) |-> PC_OUT == $past(INSTR_IN[15:0], 2)) else $error("bad target");
	a_done_once: assert property (DONE_OUT |=> !DONE_OUT) else $error("long done");
	a_pc_hold: assert property (!DONE_OUT |-> $stable(PC_OUT) && $stable(TAKEN_OUT)) else $error("pc moved");
	a_ill_quiet: assert property (ILLEGAL_OUT |-> !DONE_OUT ##1 !ILLEGAL_OUT) else $error("illegal odd");
endmodule
bind switch_test_jump switch_test_checker u_chk(.*);
`default_nettype wire

// File: dv/test_switch_test_jump.sv
`timescale 1ns/1ps
`default_nettype none
module test_switch_test_jump;
	reg clk = 0, rst = 1, st = 0;
	reg [43:0] ins = 0;
	reg [15:0] pc = 0, ix = 0;
	reg [9:0] lv = 0;
	wire [9:0] sw;
	wire dn, tk, ld, ec, il;
	wire [15:0] po;
	integer error_cnt = 0, total_checks = 0, seed = 32'ha1c28cb4, i, e, f, x;
	always #12.5 clk = ~clk;
	console_switches P (.level_in(lv), .switch_out(sw));
	switch_test_jump DUT (.REF_CLK_IN(clk), .RST_IN(rst), .START_IN(st), .INSTR_IN(ins), .PC_IN(pc), .INDEX_IN(ix), .SWITCH_IN(sw), .DONE_OUT(dn), .TAKEN_OUT(tk), .PC_LOAD_OUT(ld), .PC_OUT(po), .EXCH_CLEAR_OUT(ec), .ILLEGAL_OUT(il));
	function integer b2i(input [15:0] b);
		b2i = b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
	endfunction
	function [15:0] i2b(input integer n);
		i2b = {4'(n / 1000 % 10), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
	endfunction
	task chk(input [8*4:1] n, input [15:0] s, input [15:0] y);
		total_checks++;
		if (s !== y) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", n, y, s);
		end
	endtask
	task end_sim;
		if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		end_sim;
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 rst = 0;
		for (i = 0; i < 60; i++) begin
			e = $random(seed);
			f = $random(seed);
			ins = {4'(e[2:0]), e[7:4], e[19:8], (i % 7 == 3) ? 8'h37 : 8'h38, i2b(e[30:18])};
			pc = i ? i2b(f[12:0]) : 16'h9999;
			ix = i2b(f[28:16]);
			lv = i ? f[25:16] : 10'h000;
			st = 1;
			@(posedge clk) #1 st = 0;
			chk("ill", il, ins[23:16] != 8'h38);
			@(posedge clk) #1;
			chk("done", {dn, ec, ld}, (ins[23:16] == 8'h38) ? 3'h7 : 3'h0);
			x = (ins[39:36] < 10) && lv[ins[39:36]];
			if (ins[23:16] == 8'h38) begin
				chk("tkn", tk, x);
				chk("pc", po, x ? i2b(b2i(ins[15:0]) + (ins[40] ? b2i(ix) : 0)) : i2b(b2i(pc) + 1));
			end
		end
		end_sim;
	end
endmodule
`default_nettype wire
